// *** cdss_pkg.sv ***
// package: setup pin codes, divider table anchors, sync timing and state types
package cdss_pkg;
    // ---------------------------------------------------------------
    // four-level setup pin codes
    // ---------------------------------------------------------------
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_THIRD = 2'h1;
    localparam logic [1:0] LVL_TWO_THIRDS = 2'h2;
    localparam logic [1:0] LVL_ONE = 2'h3;
    localparam int LVL_W = 2;
    localparam int PIN_COUNT = 11;
    localparam int CNT_W = 6;
    localparam int FINE_W = 4;

    // ---------------------------------------------------------------
    // divider table, index = a + 4*b + 16*c
    // ---------------------------------------------------------------
    localparam logic [5:0] IDX_OFF = 6'h0C;
    localparam logic [5:0] IDX_PHASED = 6'h20;
    localparam logic [5:0] IDX_R4 = 6'h21;
    localparam logic [5:0] IDX_R8 = 6'h24;
    localparam logic [5:0] IDX_R16 = 6'h2B;
    localparam logic [5:0] IDX_R32 = 6'h3A;
    localparam logic [5:0] IDX_BAD = 6'h3F;
    localparam logic [5:0] RATIO_1 = 6'h01;
    localparam logic [5:0] RATIO_2 = 6'h02;
    localparam logic [5:0] RATIO_3 = 6'h03;
    localparam logic [5:0] RATIO_4 = 6'h04;
    localparam logic [5:0] RATIO_8 = 6'h08;
    localparam logic [5:0] RATIO_16 = 6'h10;
    localparam logic [5:0] RATIO_32 = 6'h20;

    // ---------------------------------------------------------------
    // sync timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_MIN_LOW_NS = 5;
    localparam int SYNC_MIN_LOW_RAW = (SYNC_MIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_MIN_LOW_CYC = (SYNC_MIN_LOW_RAW < 1) ? 1 : SYNC_MIN_LOW_RAW;
    localparam logic [2:0] WAIT_CYCLES = 3'h4;
    localparam logic [2:0] WAIT_LAST = WAIT_CYCLES - 3'h1;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_WAIT = 2'h1,
        ST_RUN = 2'h3
    } cdss_state_t;

    typedef struct packed {
        logic [1:0] phase_select_pin_b;
        logic [1:0] phase_select_pin_a;
        logic [1:0] phase_target_pin;
        logic [1:0] secondary_div_pin_c;
        logic [1:0] secondary_div_pin_b;
        logic [1:0] secondary_div_pin_a;
        logic [1:0] primary_div_pin_c;
        logic [1:0] primary_div_pin_b;
        logic [1:0] primary_div_pin_a;
        logic [1:0] logic_standard_pin;
        logic [1:0] delay_range_pin;
    } cdss_setup_t;

    typedef struct packed {
        logic off;
        logic [CNT_W-1:0] ratio;
        logic [CNT_W-1:0] phase;
    } cdss_div_t;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic out;
        logic passthru;
        logic power_down;
    } cdss_chan_t;

    typedef struct packed {
        cdss_state_t state;
        logic [2:0] wcnt;
        logic sync_s1;
        logic sync_s2;
        cdss_setup_t pin_s1;
        cdss_setup_t pin_s2;
        logic [PIN_COUNT-1:0] flt_s1;
        logic [PIN_COUNT-1:0] flt_s2;
        cdss_chan_t ch0;
        cdss_chan_t ch1;
        logic high_swing;
        logic single_ended;
        logic dly_bypass;
        logic [1:0] dly_range;
        logic [FINE_W-1:0] dly_fine;
    } cdss_regs_t;
endpackage

// *** cdss_top.sv ***
// two-output clock divider with pin setup decode and output synchronisation
`timescale 1ns/1ns

// Behaviour
// - each output divides independently, 1 to 32
// - secondary delay has three scales, 16 steps
// - power-up syncs every divided output
// - sync low holds divided outputs at fixed level
// - release waits four clocks, then aligned run
// - ratio one outputs ignore sync entirely
// - ratio one output follows input clock
// - sync sampled on input clock only; without clock no sync is taken
// - powered-off outputs are not synchronised
// - alignment keeps each output's phase offset
// - four pin levels, unconnected reads one third
// - phase target picks which output gets phase
// - secondary, range zero: bypass, phase to divider
// - secondary, range nonzero: scale and fine step
// - own nonzero divider phase beats phase pair
// - logic standard sets swing and secondary type
// - primary pattern 0/1/0 powers primary down
// - secondary pattern 0/1/0 powers secondary down
// - range levels: bypass, 1.5, 5, 10 ns
// - even ratios 50% duty, odd below half
module cdss_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sync_request_n,
    input wire cdss_pkg::cdss_setup_t setup_pins,
    input wire logic [cdss_pkg::PIN_COUNT-1:0] setup_float,
    output logic primary_clock_output,
    output logic secondary_clock_output,
    output logic primary_passthru,
    output logic secondary_passthru,
    output logic primary_power_down,
    output logic secondary_power_down,
    output logic primary_high_swing,
    output logic secondary_single_ended,
    output logic secondary_delay_bypass,
    output logic [1:0] secondary_delay_range,
    output logic [cdss_pkg::FINE_W-1:0] secondary_delay_fine
);
    // ---------------------------------------------------------------
    // table decode of one divider pin triple
    // ---------------------------------------------------------------
    function automatic cdss_pkg::cdss_div_t dec_div(
        input logic [1:0] a,
        input logic [1:0] b,
        input logic [1:0] c
    );
        cdss_pkg::cdss_div_t d;
        logic [5:0] idx;
        idx = {c, b, a};
        d.off = 1'b0;
        d.phase = '0;
        d.ratio = idx + 1'b1;
        if (idx == cdss_pkg::IDX_OFF || idx == cdss_pkg::IDX_BAD) begin
            // forbidden all-ones pattern is treated as off
            d.off = 1'b1;
            d.ratio = cdss_pkg::RATIO_1;
        end else if (idx >= cdss_pkg::IDX_R32) begin
            d.ratio = cdss_pkg::RATIO_32;
            d.phase = idx - cdss_pkg::IDX_R32 + 1'b1;
        end else if (idx >= cdss_pkg::IDX_R16) begin
            d.ratio = cdss_pkg::RATIO_16;
            d.phase = idx - cdss_pkg::IDX_R16 + 1'b1;
        end else if (idx >= cdss_pkg::IDX_R8) begin
            d.ratio = cdss_pkg::RATIO_8;
            d.phase = idx - cdss_pkg::IDX_R8 + 1'b1;
        end else if (idx >= cdss_pkg::IDX_R4) begin
            d.ratio = cdss_pkg::RATIO_4;
            d.phase = idx - cdss_pkg::IDX_R4 + 1'b1;
        end else if (idx == cdss_pkg::IDX_PHASED) begin
            d.ratio = cdss_pkg::RATIO_2;
            d.phase = idx - cdss_pkg::IDX_PHASED + 1'b1;
        end
        return d;
    endfunction

    // ---------------------------------------------------------------
    // one divider step: hold at phase load, or count and wrap
    // ---------------------------------------------------------------
    function automatic cdss_pkg::cdss_chan_t chan_step(
        input cdss_pkg::cdss_chan_t c,
        input cdss_pkg::cdss_div_t d,
        input logic [cdss_pkg::CNT_W-1:0] ph,
        input logic hold
    );
        cdss_pkg::cdss_chan_t n;
        logic [cdss_pkg::CNT_W-1:0] load;
        logic [cdss_pkg::CNT_W-1:0] high;
        n = c;
        // odd ratios get the shorter half high
        high = d.ratio >> 1;
        // phase p delays the output by p input clocks
        load = (ph == '0) ? '0 : d.ratio - ph;
        n.power_down = d.off;
        // analog bypass carries the input clock; digital path idles
        n.passthru = !d.off && d.ratio == cdss_pkg::RATIO_1;
        if (d.off || n.passthru) begin
            n.cnt = '0;
        end else if (hold) begin
            n.cnt = load;
        end else if (c.cnt >= d.ratio - 1'b1) begin
            n.cnt = '0;
        end else begin
            n.cnt = c.cnt + 1'b1;
        end
        n.out = !d.off && !n.passthru && (n.cnt < high);
        return n;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    cdss_pkg::cdss_regs_t st;
    cdss_pkg::cdss_regs_t next_st;
    logic [cdss_pkg::LVL_W*cdss_pkg::PIN_COUNT-1:0] raw_bits;
    logic [cdss_pkg::LVL_W*cdss_pkg::PIN_COUNT-1:0] lvl_bits;
    cdss_pkg::cdss_setup_t pins;
    cdss_pkg::cdss_div_t dec0;
    cdss_pkg::cdss_div_t dec1;
    logic [cdss_pkg::CNT_W-1:0] sel6;
    logic [cdss_pkg::CNT_W-1:0] ph0;
    logic [cdss_pkg::CNT_W-1:0] ph1;
    logic tgt_sec;
    logic range_zero;

    // ---------------------------------------------------------------
    // pin levels, floating pins read one third
    // ---------------------------------------------------------------
    assign raw_bits = st.pin_s2;
    for (genvar i = 0; i < cdss_pkg::PIN_COUNT; i++) begin : g_pin
        assign lvl_bits[i*cdss_pkg::LVL_W +: cdss_pkg::LVL_W] = st.flt_s2[i] ?
            cdss_pkg::LVL_THIRD : raw_bits[i*cdss_pkg::LVL_W +: cdss_pkg::LVL_W];
    end
    assign pins = lvl_bits;

    // ---------------------------------------------------------------
    // setup decode
    // ---------------------------------------------------------------
    assign dec0 = dec_div(pins.primary_div_pin_a, pins.primary_div_pin_b,
        pins.primary_div_pin_c);
    assign dec1 = dec_div(pins.secondary_div_pin_a, pins.secondary_div_pin_b,
        pins.secondary_div_pin_c);
    assign sel6 = 6'({pins.phase_select_pin_b, pins.phase_select_pin_a});
    assign tgt_sec = pins.phase_target_pin != cdss_pkg::LVL_ZERO;
    assign range_zero = pins.delay_range_pin == cdss_pkg::LVL_ZERO;
    // a phase beyond the ratio wraps rather than stalling the divider
    assign ph0 = (dec0.phase != '0) ? dec0.phase :
        (tgt_sec ? '0 : sel6 % dec0.ratio);
    assign ph1 = (dec1.phase != '0) ? dec1.phase :
        ((tgt_sec && range_zero) ? sel6 % dec1.ratio : '0);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.sync_s1 = sync_request_n;
        next_st.sync_s2 = st.sync_s1;
        next_st.pin_s1 = setup_pins;
        next_st.pin_s2 = st.pin_s1;
        next_st.flt_s1 = setup_float;
        next_st.flt_s2 = st.flt_s1;
        case (st.state)
            cdss_pkg::ST_HOLD: begin
                next_st.wcnt = '0;
                if (st.sync_s2) begin
                    next_st.state = cdss_pkg::ST_WAIT;
                end
            end
            cdss_pkg::ST_WAIT: begin
                // counts input clocks only, so a request with no clock just waits
                if (!st.sync_s2) begin
                    next_st.state = cdss_pkg::ST_HOLD;
                end else if (st.wcnt == cdss_pkg::WAIT_LAST) begin
                    next_st.state = cdss_pkg::ST_RUN;
                end else begin
                    next_st.wcnt = st.wcnt + 1'b1;
                end
            end
            cdss_pkg::ST_RUN: begin
                if (!st.sync_s2) begin
                    next_st.state = cdss_pkg::ST_HOLD;
                end
            end
            default: begin
                next_st.state = cdss_pkg::ST_HOLD;
            end
        endcase
        next_st.ch0 = chan_step(st.ch0, dec0, ph0, st.state != cdss_pkg::ST_RUN);
        next_st.ch1 = chan_step(st.ch1, dec1, ph1, st.state != cdss_pkg::ST_RUN);
        next_st.high_swing = !pins.logic_standard_pin[0];
        next_st.single_ended = pins.logic_standard_pin[1];
        if (tgt_sec && !range_zero) begin
            next_st.dly_bypass = 1'b0;
            next_st.dly_range = pins.delay_range_pin;
            next_st.dly_fine = sel6[cdss_pkg::FINE_W-1:0];
        end else begin
            next_st.dly_bypass = 1'b1;
            next_st.dly_range = cdss_pkg::LVL_ZERO;
            next_st.dly_fine = '0;
        end
    end

    // reset lands in the wait state: this is the power-on sync
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.state <= cdss_pkg::ST_WAIT;
            st.sync_s1 <= 1'b1;
            st.sync_s2 <= 1'b1;
            st.dly_bypass <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign primary_clock_output = st.ch0.out;
    assign secondary_clock_output = st.ch1.out;
    assign primary_passthru = st.ch0.passthru;
    assign secondary_passthru = st.ch1.passthru;
    assign primary_power_down = st.ch0.power_down;
    assign secondary_power_down = st.ch1.power_down;
    assign primary_high_swing = st.high_swing;
    assign secondary_single_ended = st.single_ended;
    assign secondary_delay_bypass = st.dly_bypass;
    assign secondary_delay_range = st.dly_range;
    assign secondary_delay_fine = st.dly_fine;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic same_cfg;
    logic r3run;
    assign same_cfg = dec0 == dec1 && ph0 == ph1 && !dec0.off && dec0.ratio != cdss_pkg::RATIO_1;
    assign r3run = st.state == cdss_pkg::ST_RUN && dec0.ratio == cdss_pkg::RATIO_3 && !dec0.off;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_released;
        (st.state == cdss_pkg::ST_HOLD && st.sync_s2) ##1 st.sync_s2 [*4];
    endsequence

    // ratio three a cycle earlier too, so the counter already ran on that ratio
    sequence s_third_run;
        r3run ##1 (r3run && st.ch0.out) ##1 r3run [*3];
    endsequence

    property p_ratio_range;
        !dec0.off |-> dec0.ratio >= cdss_pkg::RATIO_1 && dec0.ratio <= cdss_pkg::RATIO_32
            && ph0 < dec0.ratio;
    endproperty
    a_ratio_range: assert property (p_ratio_range)
        else $error("primary ratio or phase out of range");

    property p_wait_bounded;
        st.state == cdss_pkg::ST_WAIT |-> ##[1:4] st.state != cdss_pkg::ST_WAIT;
    endproperty
    a_wait_bounded: assert property (p_wait_bounded)
        else $error("sync wait lasted more than four clocks");

    property p_release;
        s_released |=> st.state == cdss_pkg::ST_RUN;
    endproperty
    a_release: assert property (p_release)
        else $error("outputs not running four clocks after release");

    property p_hold_static;
        (st.state != cdss_pkg::ST_RUN) ##1 (st.state != cdss_pkg::ST_RUN
            && $stable(st.pin_s2) && $stable(st.flt_s2))
            |=> $stable(st.ch0.out) && $stable(st.ch1.out);
    endproperty
    a_hold_static: assert property (p_hold_static)
        else $error("divided output moved while sync held");

    property p_align;
        (st.state == cdss_pkg::ST_WAIT && same_cfg) ##1
            (st.state == cdss_pkg::ST_RUN && same_cfg) |-> st.ch0.cnt == st.ch1.cnt;
    endproperty
    a_align: assert property (p_align)
        else $error("equal outputs not aligned after sync");

    property p_duty_three;
        s_third_run |-> st.ch0.out && !$past(st.ch0.out) && !$past(st.ch0.out, 2);
    endproperty
    a_duty_three: assert property (p_duty_three)
        else $error("ratio three duty is not one high in three");

    property p_passthru;
        (!dec0.off && dec0.ratio == cdss_pkg::RATIO_1) |=> st.ch0.passthru && !st.ch0.out;
    endproperty
    a_passthru: assert property (p_passthru)
        else $error("ratio one output not in pass-through");

    property p_passthru_secondary;
        (!dec1.off && dec1.ratio == cdss_pkg::RATIO_1) |=> st.ch1.passthru && !st.ch1.out;
    endproperty
    a_passthru_secondary: assert property (p_passthru_secondary)
        else $error("secondary ratio one output not in pass-through");

    property p_off;
        dec0.off |=> st.ch0.power_down && !st.ch0.out;
    endproperty
    a_off: assert property (p_off)
        else $error("off pattern did not power the primary down");

    property p_off_secondary;
        dec1.off |=> st.ch1.power_down && !st.ch1.out;
    endproperty
    a_off_secondary: assert property (p_off_secondary)
        else $error("off pattern did not power the secondary down");

    property p_delay_scale;
        (tgt_sec && !range_zero) |=> !st.dly_bypass
            && st.dly_range == $past(pins.delay_range_pin)
            && st.dly_fine == {$past(pins.phase_select_pin_b), $past(pins.phase_select_pin_a)};
    endproperty
    a_delay_scale: assert property (p_delay_scale)
        else $error("delay scale or fine step not applied");

    property p_delay_bypass;
        (tgt_sec && range_zero && dec1.phase == '0) |-> ph1 == sel6 % dec1.ratio
            ##1 st.dly_bypass;
    endproperty
    a_delay_bypass: assert property (p_delay_bypass)
        else $error("range zero did not bypass delay");

    property p_own_phase;
        (dec1.phase != '0 |-> ph1 == dec1.phase) and (dec0.phase != '0 |-> ph0 == dec0.phase);
    endproperty
    a_own_phase: assert property (p_own_phase)
        else $error("phase pair overrode divider phase");

    property p_float;
        (st.flt_s2[0] |-> pins.delay_range_pin == cdss_pkg::LVL_THIRD)
            and (st.flt_s2[1] |-> pins.logic_standard_pin == cdss_pkg::LVL_THIRD);
    endproperty
    a_float: assert property (p_float)
        else $error("floating pin not read as one third");
endmodule // cdss_top

// *** cdss_board.sv ***
// board model: setup strapping with open pins and the sync request driver
`timescale 1ns/1ns
module cdss_board (
    input wire logic ref_clk,
    input wire logic sync_req,
    input wire cdss_pkg::cdss_setup_t strap,
    input wire logic [cdss_pkg::PIN_COUNT-1:0] open_pins,
    output cdss_pkg::cdss_setup_t setup_pins,
    output logic [cdss_pkg::PIN_COUNT-1:0] setup_float,
    output logic sync_request_n
);
    logic stretch;
    logic [21:0] raw;
    // an open pin carries no code; drive the inverse so reading it shows up
    always_comb begin
        raw = strap;
        for (int i = 0; i < cdss_pkg::PIN_COUNT; i++) begin
            if (open_pins[i]) begin
                raw[2*i +: 2] = ~raw[2*i +: 2];
            end
        end
        setup_pins = raw;
    end
    assign setup_float = open_pins;
    // low stretched one clock past release, far above the minimum
    always_ff @(posedge ref_clk) begin
        stretch <= sync_req;
    end
    // driven high when idle, never left floating
    assign sync_request_n = ~(sync_req | stretch);
endmodule // cdss_board

// *** tb_top.sv ***
// testbench: reset, divider, sync, power-down and pin decode scenarios
`timescale 1ns/1ns
module tb_top;
    logic ref_clk;
    logic rst;
    logic sync_req;
    cdss_pkg::cdss_setup_t strap;
    logic [cdss_pkg::PIN_COUNT-1:0] open_pins;
    cdss_pkg::cdss_setup_t setup_pins;
    logic [cdss_pkg::PIN_COUNT-1:0] setup_float;
    logic sync_request_n;
    logic pri, sec, pri_pt, sec_pt, pri_pd, sec_pd, swing, single, bypass;
    logic [1:0] dly_range;
    logic [3:0] fine;
    int error_cnt;
    int comparisons;

    cdss_board cdss_board_inst (.ref_clk(ref_clk), .sync_req(sync_req), .strap(strap),
        .open_pins(open_pins), .setup_pins(setup_pins), .setup_float(setup_float),
        .sync_request_n(sync_request_n));
    cdss_top cdss_top_inst (.ref_clk(ref_clk), .rst(rst), .sync_request_n(sync_request_n),
        .setup_pins(setup_pins), .setup_float(setup_float), .primary_clock_output(pri),
        .secondary_clock_output(sec), .primary_passthru(pri_pt), .secondary_passthru(sec_pt),
        .primary_power_down(pri_pd), .secondary_power_down(sec_pd),
        .primary_high_swing(swing), .secondary_single_ended(single),
        .secondary_delay_bypass(bypass), .secondary_delay_range(dly_range),
        .secondary_delay_fine(fine));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic set_div(input logic s, input logic [5:0] ix);
        if (s) begin
            strap.secondary_div_pin_a = ix[1:0];
            strap.secondary_div_pin_b = ix[3:2];
            strap.secondary_div_pin_c = ix[5:4];
        end else begin
            strap.primary_div_pin_a = ix[1:0];
            strap.primary_div_pin_b = ix[3:2];
            strap.primary_div_pin_c = ix[5:4];
        end
    endtask
    // request crosses the synchroniser; release, four-clock wait and margin follow
    task automatic sync_pulse();
        step(1);
        sync_req = 1'b1;
        step(4);
        sync_req = 1'b0;
        step(14);
    endtask
    task automatic give_verdict();
        $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_reset();
        int tr;
        logic last;
        step(12);
        check({pri, sec, pri_pt, sec_pt, pri_pd, sec_pd, swing, bypass}, 8'h01);
        check({single, dly_range, fine}, 8'h00);
        rst = 1'b0;
        tr = 0;
        last = pri;
        repeat (24) begin
            step(1);
            tr += int'(pri != last);
            last = pri;
        end
        check(8'(tr != 0), 8'h01);
    endtask
    task automatic test_ratio();
        logic [5:0] ix [5] = '{6'h01, 6'h02, 6'h04, 6'h07, 6'h1F};
        int rt [5] = '{2, 3, 5, 8, 32};
        int hi;
        int tr;
        logic last;
        for (int i = 0; i < 5; i++) begin
            set_div(1'b0, ix[i]);
            set_div(1'b1, ix[i]);
            step(6);
            sync_pulse();
            hi = 0;
            tr = 0;
            last = pri;
            for (int k = 0; k < 2 * rt[i]; k++) begin
                step(1);
                hi += int'(pri);
                tr += int'(pri != last);
                last = pri;
                check(sec, pri);
            end
            check(8'(tr), 8'h04);
            check(8'(hi), 8'(2 * (rt[i] / 2)));
        end
    endtask
    task automatic test_sync();
        logic p [8];
        logic s [8];
        int n;
        set_div(1'b0, 6'h03);
        set_div(1'b1, 6'h22);
        strap.phase_target_pin = cdss_pkg::LVL_THIRD;
        strap.delay_range_pin = cdss_pkg::LVL_ZERO;
        strap.phase_select_pin_a = cdss_pkg::LVL_THIRD;
        step(6);
        sync_req = 1'b1;
        step(6);
        repeat (8) begin
            step(1);
            check({pri, sec}, 8'h02);
        end
        sync_req = 1'b0;
        repeat (6) begin
            step(1);
            check({pri, sec}, 8'h02);
        end
        n = 0;
        while ({pri, sec} == 2'b10 && n < 8) begin
            step(1);
            n++;
        end
        check({pri, sec}, 8'h01);
        for (int k = 0; k < 8; k++) begin
            step(1);
            p[k] = pri;
            s[k] = sec;
        end
        for (int k = 2; k < 8; k++) begin
            check(s[k], p[k-2]);
        end
    endtask
    task automatic test_passthru();
        set_div(1'b0, 6'h00);
        set_div(1'b1, 6'h01);
        step(6);
        check({pri_pt, sec_pt, pri}, 8'h04);
        sync_req = 1'b1;
        step(8);
        check({pri_pt, pri}, 8'h02);
        sync_req = 1'b0;
        step(12);
    endtask
    task automatic test_power();
        int tr;
        logic last;
        set_div(1'b0, cdss_pkg::IDX_OFF);
        set_div(1'b1, cdss_pkg::IDX_OFF);
        step(6);
        check({pri_pd, sec_pd, pri, sec, pri_pt, sec_pt}, 8'h30);
        sync_pulse();
        check({pri_pd, sec_pd, pri, sec}, 8'h0C);
        set_div(1'b1, 6'h01);
        step(6);
        sync_pulse();
        tr = 0;
        last = sec;
        repeat (4) begin
            step(1);
            tr += int'(sec != last);
            last = sec;
        end
        check({pri_pd, sec_pd, 6'(tr)}, 8'h84);
    endtask
    task automatic test_standard();
        for (int l = 0; l < 4; l++) begin
            strap.logic_standard_pin = 2'(l);
            step(6);
            check({swing, single}, {6'h00, l == 0 || l == 2, l >= 2});
        end
        strap.logic_standard_pin = cdss_pkg::LVL_ZERO;
        open_pins[1] = 1'b1;
        step(6);
        check({swing, single}, 8'h00);
        open_pins = '0;
    endtask
    task automatic test_delay();
        logic [3:0] fv [3] = '{4'h0, 4'h6, 4'hF};
        set_div(1'b1, 6'h03);
        strap.phase_target_pin = cdss_pkg::LVL_ONE;
        for (int r = 0; r < 4; r++) begin
            for (int f = 0; f < 3; f++) begin
                strap.delay_range_pin = 2'(r);
                strap.phase_select_pin_a = fv[f][1:0];
                strap.phase_select_pin_b = fv[f][3:2];
                step(6);
                if (r == 0) begin
                    check({bypass, dly_range, fine}, 8'h40);
                end else begin
                    check({bypass, dly_range, fine}, {2'h0, 2'(r), fv[f]});
                end
            end
        end
        strap.phase_target_pin = cdss_pkg::LVL_ZERO;
        step(6);
        check({bypass, dly_range, fine}, 8'h40);
    endtask

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        error_cnt = 0;
        comparisons = 0;
        strap = '0;
        open_pins = '0;
        sync_req = 1'b0;
        rst = 1'b1;
        strap.primary_div_pin_a = cdss_pkg::LVL_ONE;
        test_reset();
        test_ratio();
        test_sync();
        test_passthru();
        test_power();
        test_standard();
        test_delay();
        give_verdict();
    end
    // about 500 cycles expected; allow forty times that
    initial begin
        #400000;
        error_cnt++;
        give_verdict();
    end
endmodule // tb_top
